// ===== rtl/perf_counter_pkg.sv
package perf_counter_pkg;
  localparam logic [7:0]  FRAME_ERR_OFS  = 8'h24;
  localparam logic [7:0]  PARITY_OFS     = 8'h26;
  localparam logic [7:0]  CBIT_OFS       = 8'h28;
  localparam logic [7:0]  FEBE_OFS       = 8'h2a;
  localparam logic [7:0]  CONTROL_OFS    = 8'h2c;
  localparam int          CTL_SEL_LSB    = 0;
  localparam int          CTL_COUNT_LOF  = 2;
  localparam int          CTL_E3         = 3;
  localparam int          CTL_CBIT_MODE  = 4;
  localparam int          CTL_AUTO_UPD   = 5;
  localparam int          CTL_MANUAL_UPD = 6;
  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam int          SECOND_NS      = 1000000000;
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          SECOND_CYCLES  = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  typedef enum logic [1:0] {
    SEL_LOF    = 2'b00,
    SEL_FM     = 2'b01,
    SEL_F_ONLY = 2'b10,
    SEL_M_ONLY = 2'b11
  } frame_sel_t;
endpackage

// ===== rtl/perf_error_counters.sv
`timescale 1ns/1ps
module perf_error_counters #(
  parameter int CW            = 16,
  parameter int SECOND_CYCLES = perf_counter_pkg::SECOND_CYCLES
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          lossOfFrame,
  input  wire logic          fBitError,
  input  wire logic          mBitError,
  input  wire logic [3:0]    alignBitErrors,
  input  wire logic          alignWordError,
  input  wire logic          parityStrobe,
  input  wire logic [1:0]    parityBitsRx,
  input  wire logic          parityCalc,
  input  wire logic          cbitStrobe,
  input  wire logic [2:0]    cbit_parity_overhead_bits,
  input  wire logic          cbitCalc,
  input  wire logic          febeStrobe,
  input  wire logic [2:0]    febeBits,
  input  wire logic          remoteAlarmBit,
  input  wire logic          external_counter_update_input,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  // Widths below 16 exist only to reach saturation quickly in simulation.
  if (CW < 1 || CW > 16) begin
    $error("Counter width must be 1 to 16.");
  end
  if (SECOND_CYCLES < 2) begin
    $error("Second interval too short.");
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // All event inputs arrive from the line clock domain as levels held for one
  // line event; each passes two flip-flops, and strobes are edge detected.
  localparam int NIN = 23;
  logic [NIN-1:0] meta_reg;
  logic [NIN-1:0] sync_reg;
  logic [NIN-1:0] prev_reg;
  logic [NIN-1:0] rawIn;
  assign rawIn = {external_counter_update_input, remoteAlarmBit, febeBits,
                  febeStrobe, cbitCalc, cbit_parity_overhead_bits, cbitStrobe,
                  parityCalc, parityBitsRx, parityStrobe, alignWordError,
                  alignBitErrors, mBitError, fBitError, lossOfFrame};
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= rawIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  logic       lof;
  logic       lofRise;
  logic       fRise;
  logic       mRise;
  logic       wordRise;
  logic [3:0] alignNew;
  logic       parRise;
  logic       cbRise;
  logic       febeRise;
  logic       extRise;
  assign lof      = sync_reg[0];
  assign lofRise  = sync_reg[0] & ~prev_reg[0];
  assign fRise    = sync_reg[1] & ~prev_reg[1];
  assign mRise    = sync_reg[2] & ~prev_reg[2];
  assign alignNew = sync_reg[6:3] & ~prev_reg[6:3];
  assign wordRise = sync_reg[7] & ~prev_reg[7];
  assign parRise  = sync_reg[8] & ~prev_reg[8];
  assign cbRise   = sync_reg[12] & ~prev_reg[12];
  assign febeRise = sync_reg[17] & ~prev_reg[17];
  assign extRise  = sync_reg[22] & ~prev_reg[22];

  // ==========================================================================
  // Control register and update timing
  // ==========================================================================
  logic [31:0] control_reg;
  logic [1:0]  frameSel;
  logic        countInLof;
  logic        e3Mode;
  logic        cbitMode;
  logic        autoUpdate;
  logic        manualUpdate;
  assign frameSel     = control_reg[perf_counter_pkg::CTL_SEL_LSB +: 2];
  assign countInLof   = control_reg[perf_counter_pkg::CTL_COUNT_LOF];
  assign e3Mode       = control_reg[perf_counter_pkg::CTL_E3];
  assign cbitMode     = control_reg[perf_counter_pkg::CTL_CBIT_MODE];
  assign autoUpdate   = control_reg[perf_counter_pkg::CTL_AUTO_UPD];
  assign manualUpdate = control_reg[perf_counter_pkg::CTL_MANUAL_UPD];

  logic [31:0] second_reg;
  logic        manualPrev_reg;
  logic        update;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      second_reg     <= '0;
      manualPrev_reg <= 1'b0;
    end else begin
      manualPrev_reg <= manualUpdate;
      if (second_reg == 32'(SECOND_CYCLES - 1)) second_reg <= '0;
      else second_reg <= second_reg + 32'h0000_0001;
    end
  end
  assign update = (autoUpdate && second_reg == 32'(SECOND_CYCLES - 1)) ||
                  (!autoUpdate && ((manualUpdate && !manualPrev_reg) ||
                                   extRise));

  // ==========================================================================
  // Event qualification
  // ==========================================================================
  function automatic logic [2:0] pop4(input logic [3:0] v);
    pop4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
  endfunction

  localparam logic [CW-1:0] CNT_MAX  = '1;
  localparam logic [CW-1:0] CNT_ZERO = CW'(perf_counter_pkg::COUNT_RESET);

  function automatic logic [CW-1:0] satAdd(input logic [CW-1:0] c,
                                           input logic [2:0]    n);
    logic [16:0] s;
    s = 17'(c) + 17'(n);
    satAdd = (s > 17'(CNT_MAX)) ? CNT_MAX : s[CW-1:0];
  endfunction

  logic       gate;
  logic [2:0] frameInc;
  logic       parErr;
  logic       cbErr;
  logic       febeErr;
  assign gate = countInLof || !lof;
  always_comb begin
    frameInc = 3'h0;
    unique case (perf_counter_pkg::frame_sel_t'(frameSel))
      perf_counter_pkg::SEL_LOF:
        frameInc = {2'b00, lofRise};
      perf_counter_pkg::SEL_FM:
        if (gate) frameInc = e3Mode ? pop4(alignNew) :
                                      {2'b00, fRise} + {2'b00, mRise};
      perf_counter_pkg::SEL_F_ONLY:
        if (gate) frameInc = {2'b00, e3Mode ? wordRise : fRise};
      perf_counter_pkg::SEL_M_ONLY:
        if (gate && !e3Mode) frameInc = {2'b00, mRise};
    endcase
  end
  assign parErr = parRise && gate && !e3Mode &&
                  ((sync_reg[10] != sync_reg[9]) ||
                   (sync_reg[9] != sync_reg[11]));
  assign cbErr = cbRise && gate && !e3Mode && cbitMode &&
                 (((sync_reg[13] & sync_reg[14]) |
                   (sync_reg[13] & sync_reg[15]) |
                   (sync_reg[14] & sync_reg[15])) != sync_reg[16]);
  assign febeErr = febeRise && gate &&
                   (e3Mode ? sync_reg[21] :
                    (cbitMode && sync_reg[20:18] != 3'b111));

  // ==========================================================================
  // Live and latched counters
  // ==========================================================================
  logic [CW-1:0] liveFrame_reg;
  logic [CW-1:0] livePar_reg;
  logic [CW-1:0] liveCb_reg;
  logic [CW-1:0] liveFebe_reg;
  logic [CW-1:0] frame_error_counter_reg;
  logic [CW-1:0] t3_parity_error_count_reg;
  logic [CW-1:0] cbit_parity_error_count_reg;
  logic [CW-1:0] far_end_block_or_remote_alarm_count_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      liveFrame_reg <= CNT_ZERO;
      livePar_reg   <= CNT_ZERO;
      liveCb_reg    <= CNT_ZERO;
      liveFebe_reg  <= CNT_ZERO;
    end else if (update) begin
      // An event in the update cycle starts the new interval.
      liveFrame_reg <= satAdd(CNT_ZERO, frameInc);
      livePar_reg   <= satAdd(CNT_ZERO, {2'b00, parErr});
      liveCb_reg    <= satAdd(CNT_ZERO, {2'b00, cbErr});
      liveFebe_reg  <= satAdd(CNT_ZERO, {2'b00, febeErr});
    end else begin
      liveFrame_reg <= satAdd(liveFrame_reg, frameInc);
      livePar_reg   <= satAdd(livePar_reg, {2'b00, parErr});
      liveCb_reg    <= satAdd(liveCb_reg, {2'b00, cbErr});
      liveFebe_reg  <= satAdd(liveFebe_reg, {2'b00, febeErr});
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      frame_error_counter_reg                 <= CNT_ZERO;
      t3_parity_error_count_reg               <= CNT_ZERO;
      cbit_parity_error_count_reg             <= CNT_ZERO;
      far_end_block_or_remote_alarm_count_reg <= CNT_ZERO;
    end else if (update) begin
      frame_error_counter_reg                 <= liveFrame_reg;
      t3_parity_error_count_reg               <= livePar_reg;
      cbit_parity_error_count_reg             <= liveCb_reg;
      far_end_block_or_remote_alarm_count_reg <= liveFebe_reg;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  // Register offsets are word indices; byte address is four times the index.
  localparam logic [7:0] FE_ADDR = {perf_counter_pkg::FRAME_ERR_OFS[5:0], 2'b00};
  localparam logic [7:0] PA_ADDR = {perf_counter_pkg::PARITY_OFS[5:0], 2'b00};
  localparam logic [7:0] CB_ADDR = {perf_counter_pkg::CBIT_OFS[5:0], 2'b00};
  localparam logic [7:0] FB_ADDR = {perf_counter_pkg::FEBE_OFS[5:0], 2'b00};
  localparam logic [7:0] CT_ADDR = {perf_counter_pkg::CONTROL_OFS[5:0], 2'b00};
  logic [7:0] awAddr_reg;
  logic       awHave_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        wHave_reg;
  logic        doWrite;
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 8'h00;
      wData_reg     <= 32'h0000_0000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= perf_counter_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHave_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_reg   <= 1'b0;
        wHave_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_reg == CT_ADDR)
                        ? perf_counter_pkg::RESP_OKAY
                        : perf_counter_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      control_reg <= perf_counter_pkg::CONTROL_RESET;
    end else if (doWrite && awAddr_reg == CT_ADDR) begin
      for (int b = 0; b < 4; b++) begin
        if (wStrb_reg[b]) control_reg[8*b +: 8] <= wData_reg[8*b +: 8];
      end
    end
  end

  logic [31:0] readData;
  logic        readOk;
  always_comb begin
    readData = 32'h0000_0000;
    readOk   = 1'b1;
    unique case (s_axi_araddr)
      FE_ADDR:
        readData = 32'(frame_error_counter_reg);
      PA_ADDR:
        readData = 32'(t3_parity_error_count_reg);
      CB_ADDR:
        readData = 32'(cbit_parity_error_count_reg);
      FB_ADDR:
        readData = 32'(far_end_block_or_remote_alarm_count_reg);
      CT_ADDR:
        readData = control_reg;
      default:
        readOk = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= perf_counter_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= readData;
        s_axi_rresp  <= readOk ? perf_counter_pkg::RESP_OKAY
                               : perf_counter_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== verification/framer_line_model.sv
`timescale 1ns/1ps
// =====================================================================
// Receive framer event source: strobes, levels and overhead fields.
module framer_line_model (
  input  wire logic        sys_clk,
  output logic      [11:0] eventLines,
  output logic      [2:0]  fieldBits,
  output logic             fieldCalc
);
  initial begin
    eventLines = '0;
    fieldBits = '0;
    fieldCalc = 1'b0;
  end
  task automatic pulse(input int b);
    @(posedge sys_clk);
    eventLines[b] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    eventLines[b] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic level(input logic v);
    @(posedge sys_clk);
    eventLines[0] <= v;
    repeat (4) @(posedge sys_clk);
  endtask
  // Fields settle before the strobe and are inverted four cycles after it falls.
  task automatic frame(input int b, input logic [2:0] d, input logic c);
    @(posedge sys_clk);
    fieldBits <= d;
    fieldCalc <= c;
    repeat (2) @(posedge sys_clk);
    pulse(b);
    fieldBits <= ~d;
    fieldCalc <= ~c;
  endtask
endmodule

// ===== verification/perf_error_counters_assertions.sv
`timescale 1ns/1ps
// =====================================================================
// Bus and counter checks seen from the top-level ports.
module perf_error_checks #(
  parameter int CW = 16
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  localparam logic [7:0] FE  = 8'(perf_counter_pkg::FRAME_ERR_OFS << 2);
  localparam logic [7:0] CTL = 8'(perf_counter_pkg::CONTROL_OFS << 2);
  logic [7:0] rdAddr;
  logic [7:0] wrAddr;
  logic       rdMapped;
  always_ff @(posedge sys_clk) begin
    if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
  end
  always_ff @(posedge sys_clk) begin
    if (s_axi_awvalid && s_axi_awready) wrAddr <= s_axi_awaddr;
  end
  assign rdMapped = rdAddr[2:0] == 3'h0 && rdAddr >= FE && rdAddr <= CTL;
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_ar_taken: assert property (
    $rose(s_axi_arvalid) |=> s_axi_arready)
    else $error("read address not taken");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  chk_counter_width: assert property (
    s_axi_rvalid && s_axi_rresp == perf_counter_pkg::RESP_OKAY
    && rdAddr != CTL |-> s_axi_rdata[31:CW] == '0)
    else $error("counter wider than allowed");
  chk_unmapped_read: assert property (
    s_axi_rvalid && !rdMapped |-> s_axi_rdata == 32'h0
    && s_axi_rresp == perf_counter_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  chk_ro_write: assert property (
    s_axi_bvalid && wrAddr != CTL
    |-> s_axi_bresp == perf_counter_pkg::RESP_SLVERR)
    else $error("counter write not refused");
  chk_reset_idle: assert property (
    $rose(rstn) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus busy after reset");
endmodule
bind perf_error_counters perf_error_checks #(.CW(CW)) checks (
  .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== verification/t3_e3_performance_error_counters_test.sv
`timescale 1ns/1ps
module t3_e3_performance_error_counters_test;
  localparam int CW = 4;
  localparam logic [7:0] FE = 8'(perf_counter_pkg::FRAME_ERR_OFS << 2);
  localparam logic [7:0] PA = 8'(perf_counter_pkg::PARITY_OFS << 2);
  localparam logic [7:0] CB = 8'(perf_counter_pkg::CBIT_OFS << 2);
  localparam logic [7:0] FB = 8'(perf_counter_pkg::FEBE_OFS << 2);
  localparam logic [7:0] CT = 8'(perf_counter_pkg::CONTROL_OFS << 2);
  localparam logic [1:0] OK = perf_counter_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = perf_counter_pkg::RESP_SLVERR;
  localparam logic [31:0] E3 = 32'h1 << perf_counter_pkg::CTL_E3;
  localparam logic [31:0] LOFC = 32'h1 << perf_counter_pkg::CTL_COUNT_LOF;
  localparam logic [31:0] CBM = 32'h1 << perf_counter_pkg::CTL_CBIT_MODE;
  localparam logic [31:0] AUTO = 32'h1 << perf_counter_pkg::CTL_AUTO_UPD;
  localparam logic [31:0] MAN = 32'h1 << perf_counter_pkg::CTL_MANUAL_UPD;
  localparam logic [15:0] T3EXP [4] = '{16'h1, 16'h5, 16'h2, 16'h3};
  localparam logic [15:0] E3EXP [3] = '{16'h1, 16'h2, 16'h1};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] ev;
  logic [2:0] fb;
  logic fc;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  always #20 sys_clk = ~sys_clk;
  perf_error_counters #(.CW(CW), .SECOND_CYCLES(50)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .lossOfFrame(ev[0]),
    .fBitError(ev[1]), .mBitError(ev[2]), .alignBitErrors(ev[6:3]),
    .alignWordError(ev[7]), .parityStrobe(ev[8]), .parityBitsRx(fb[1:0]),
    .parityCalc(fc), .cbitStrobe(ev[9]), .cbit_parity_overhead_bits(fb),
    .cbitCalc(fc), .febeStrobe(ev[10]), .febeBits(fb),
    .remoteAlarmBit(fc), .external_counter_update_input(ev[11]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  framer_line_model line (.sys_clk(sys_clk), .eventLines(ev),
    .fieldBits(fb), .fieldCalc(fc));
  // =====================================================================
  // Bus tasks and comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (awready === 1'b1) ad = 1'b1;
      if (wready === 1'b1) wd = 1'b1;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({30'h0, r}, {30'h0, OK});
    chk(d, {16'h0, e});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // =====================================================================
  // Test sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    expect_reg(FE, 16'h0);
    expect_reg(PA, 16'h0);
    expect_reg(CB, 16'h0);
    expect_reg(FB, 16'h0);
    rd(8'h00, d, r);
    chk({30'h0, r}, {30'h0, ERR});
    wr(PA, 32'h5, ERR);
    // Each pass: one LOF, two F errors, three M errors.
    for (int s = 0; s < 4; s++) begin
      wr(CT, 32'(s), OK);
      line.pulse(11);
      line.pulse(0);
      repeat (2) line.pulse(1);
      repeat (3) line.pulse(2);
      line.pulse(11);
      expect_reg(FE, T3EXP[s]);
    end
    // The E3 pass leaves out select 11, which is illegal there.
    for (int s = 0; s < 3; s++) begin
      wr(CT, 32'(s) | E3, OK);
      line.pulse(11);
      line.pulse(0);
      line.pulse(3);
      line.pulse(4);
      line.pulse(7);
      line.pulse(11);
      expect_reg(FE, E3EXP[s]);
    end
    wr(CT, CBM, OK);
    line.pulse(11);
    line.frame(8, 3'b001, 1'b0);
    line.frame(8, 3'b000, 1'b0);
    line.frame(8, 3'b011, 1'b0);
    line.frame(8, 3'b000, 1'b1);
    line.frame(9, 3'b110, 1'b1);
    line.frame(9, 3'b100, 1'b1);
    line.frame(9, 3'b011, 1'b0);
    line.frame(10, 3'b111, 1'b0);
    line.frame(10, 3'b101, 1'b0);
    line.frame(10, 3'b000, 1'b0);
    line.pulse(11);
    expect_reg(PA, 16'h3);
    expect_reg(CB, 16'h2);
    expect_reg(FB, 16'h2);
    wr(CT, E3, OK);
    line.pulse(11);
    for (int i = 0; i < 3; i++) line.frame(10, 3'b000, i != 1);
    line.pulse(11);
    expect_reg(FB, 16'h2);
    for (int g = 0; g < 2; g++) begin
      wr(CT, 32'h2 | CBM | (g ? LOFC : 32'h0), OK);
      line.pulse(11);
      line.level(1'b1);
      line.pulse(1);
      line.frame(8, 3'b001, 1'b0);
      line.frame(9, 3'b100, 1'b1);
      line.frame(10, 3'b101, 1'b0);
      line.level(1'b0);
      line.pulse(11);
      expect_reg(FE, 16'(g));
      expect_reg(PA, 16'(g));
      expect_reg(CB, 16'(g));
      expect_reg(FB, 16'(g));
    end
    wr(CT, 32'h2, OK);
    line.pulse(11);
    line.pulse(1);
    wr(CT, 32'h2 | MAN, OK);
    expect_reg(FE, 16'h1);
    line.pulse(11);
    expect_reg(FE, 16'h0);
    repeat (18) line.pulse(1);
    line.pulse(11);
    expect_reg(FE, 16'((1 << CW) - 1));
    line.pulse(11);
    wr(CT, 32'h2 | AUTO, OK);
    line.pulse(1);
    d = '0;
    for (int i = 0; i < 40 && d === '0; i++) rd(FE, d, r);
    chk(d, 32'h1);
    // Byte lane 0 is masked, so the control bits keep their value.
    wstrb <= 4'he;
    wr(CT, 32'h0000_0100, OK);
    wstrb <= 4'hf;
    rd(CT, d, r);
    chk(d, 32'h0000_0122);
    conclude();
  end
endmodule
